// ==== sefp_pkg.sv ====
package sefp_pkg;

   // Control register field positions.
   localparam int CR_IRQ_EN_BIT  = 7;
   localparam int CR_PE_BIT      = 6;
   localparam int CR_BAUD2_BIT   = 5;
   localparam int CR_MASTER_BIT  = 4;
   localparam int CR_CLOCK_IDLE_LEVEL_BIT    = 3;
   localparam int CR_CAPTURE_EDGE_SELECT_BIT    = 2;
   localparam int CR_BAUD1_BIT   = 1;
   localparam int CR_BAUD0_BIT   = 0;

   // Control/status register field positions.
   localparam int CSR_TCF_BIT    = 7;
   localparam int CSR_WRITE_COLLISION_FLAG_BIT   = 6;
   localparam int CSR_OVR_BIT    = 5;
   localparam int CSR_MODE_FAULT_FLAG_BIT   = 4;
   localparam int CSR_SSM_BIT    = 1;
   localparam int CSR_SSI_BIT    = 0;

   // Values after reset.
   localparam logic [7:0] CR_RESET_VALUE  = 8'h00;
   localparam logic [7:0] CSR_RESET_VALUE = 8'h00;
   localparam logic [7:0] DR_RESET_VALUE  = 8'h00;

   // Master serial clock: CLK cycles per half period of the serial clock.
   localparam int          MASTER_HALF_CYCLES = 4;
   localparam logic [2:0]  MASTER_DIV_LAST    = 3'(MASTER_HALF_CYCLES - 1);
   // Sixteen clock edges per byte, then one closing tick.
   localparam logic [4:0]  EDGE_LAST          = 5'h10;
   localparam logic [2:0]  BIT_LAST           = 3'h7;

   // State of the CPU-clock side.
   typedef struct packed {
      logic       irq_en;
      logic       pe;
      logic       master;
      logic       clock_idle_level;
      logic       capture_edge_select;
      logic [2:0] baud;
      logic       ssm;
      logic       soft_select_level;
      logic       tcf;
      logic       write_collision_flag;
      logic       overrun_flag;
      logic       mode_fault_flag;
      logic       seen_tcf;
      logic       seen_write_collision_flag;
      logic       seen_mode_fault_flag;
      logic [7:0] rx;
      logic [7:0] tx;
      logic       busy;
      logic [4:0] edge_cnt;
      logic [2:0] div;
      logic [7:0] sh;
      logic       cap_bit;
      logic       sck;
      logic       ss_s1;
      logic       ss_s2;
      logic       miso_s1;
      logic       miso_s2;
      logic       done_s1;
      logic       done_s2;
      logic       done_s3;
      logic       mid_s1;
      logic       mid_s2;
      logic       halted;
      logic       armed;
   } sefp_core_t;

   // State of the serial-clock side (slave shifting).
   typedef struct packed {
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] rx;
      logic       done_tgl;
      logic       mid;
   } sefp_link_t;

endpackage

// ==== sefp_spi.sv ====
`timescale 1ns/1ps
// Operation
// R1: Four clock modes from polarity and phase.
// R2: Software disables before changing polarity between bytes.
// R3: Master with select low is a fault.
// R4: Fault sets flag and may interrupt.
// R5: Fault clears peripheral enable.
// R6: Fault clears master select.
// R7: Fault flag clears by status read, control write.
// R8: Enable and master ignored while fault pending.
// R9: Select held high during fault clearing.
// R10: New byte with completion flag set overruns.
// R11: Overrun sets flag and may interrupt.
// R12: Buffer keeps first byte, later ones dropped.
// R13: Status read clears overrun flag.
// R14: Data write while busy collides, discarded.
// R15: Collision flag never raises an interrupt.
// R16: Collision clears by status read, data read.
// R17: Wait mode normal; enabled events wake.
// R18: Halt freezes registers until woken.
// R19: Slave completion wakes Halt; extras overrun.
// R20: Halt wake needs select low at entry.
// R21: Completion exits Halt; fault, overrun do not.
// R22: One vector, gated by enable and mask.
module sefp_spi
   import sefp_pkg::*;
(
   // Clock and reset.
   input  wire logic       CLK,
   input  wire logic       RESETN,
   // Control register access.
   input  wire logic       CR_WR,
   input  wire logic [7:0] CR_WDATA,
   output logic      [7:0] CR_RDATA,
   // Control/status register access.
   input  wire logic       CSR_RD,
   input  wire logic       CSR_WR,
   input  wire logic [7:0] CSR_WDATA,
   output logic      [7:0] CSR_RDATA,
   // Data register access.
   input  wire logic       DR_RD,
   input  wire logic       DR_WR,
   input  wire logic [7:0] DR_WDATA,
   output logic      [7:0] DR_RDATA,
   // CPU power and interrupt.
   input  wire logic       CPU_IRQ_MASK,
   input  wire logic       HALT_MODE,
   output logic            IRQ,
   output logic            WAKE_HALT,
   // Serial link pins.
   input  wire logic       SS_N_IN,
   input  wire logic       SCK_IN,
   output logic            SCK_OUT,
   output logic            SCK_OE_N,
   input  wire logic       MOSI_IN,
   output logic            MOSI_OUT,
   output logic            MOSI_OE_N,
   input  wire logic       MISO_IN,
   output logic            MISO_OUT,
   output logic            MISO_OE_N
);

   sefp_core_t c;
   sefp_core_t next_c;
   sefp_link_t l;
   sefp_link_t next_l;

   logic ss_int;
   logic running;
   logic slave_done;
   logic slave_mid;
   logic link_en;
   logic link_clk;
   logic master_done;
   logic done_evt;
   logic clr_tcf;
   logic fault;
   logic collide;

   // Internal select comes from the soft level or the synchronised pin.
   assign ss_int     = c.ssm ? c.soft_select_level : c.ss_s2;
   assign running    = !c.halted;
   assign slave_done = c.done_s2 ^ c.done_s3;
   assign slave_mid  = c.mid_s2 && !c.master && c.pe && !ss_int;
   assign link_en    = c.pe && !c.master && !ss_int;
   assign fault      = running && c.master && !ss_int; // see R3
   assign clr_tcf    = running && c.tcf && c.seen_tcf && (DR_RD || DR_WR);
   assign collide    = running && DR_WR && (c.busy || slave_mid); // see R14

   // Capture edge becomes the rising edge of this clock in all four modes.
   assign link_clk = SCK_IN ^ (c.clock_idle_level ^ c.capture_edge_select); // see R1

   // Register readback views.
   assign CR_RDATA  = {c.irq_en, c.pe, c.baud[2], c.master,
                       c.clock_idle_level, c.capture_edge_select, c.baud[1:0]};
   assign CSR_RDATA = {c.tcf, c.write_collision_flag, c.overrun_flag, c.mode_fault_flag, 2'h0, c.ssm, c.soft_select_level};
   assign DR_RDATA  = c.rx;

   // One shared request; the collision flag takes no part in it.
   assign IRQ = c.irq_en && !CPU_IRQ_MASK
                && (c.tcf || c.mode_fault_flag || c.overrun_flag); // see R15, R17, R22
   // Only completion leaves Halt, and only when armed at entry.
   assign WAKE_HALT = c.halted && c.armed && c.irq_en
                      && c.tcf; // see R19, R21

   // Pin drive: master drives clock and MOSI, selected slave drives MISO.
   assign SCK_OUT   = c.sck;
   assign MOSI_OUT  = c.sh[7];
   assign SCK_OE_N  = !(c.pe && c.master); // see R5
   assign MOSI_OE_N = !(c.pe && c.master);
   assign MISO_OE_N = !link_en;
   assign MISO_OUT  = (l.cnt == 3'h0) ? c.tx[7] : l.sh[7];

   // Core next state: synchronisers, master engine, flags and registers.
   always_comb begin
      logic [7:0] mbyte;
      logic [7:0] dbyte;
      logic       tick;
      logic       cap_now;
      logic       shift_now;
      mbyte     = c.sh;
      dbyte     = l.rx;
      tick      = 1'b0;
      cap_now   = 1'b0;
      shift_now = 1'b0;
      master_done = 1'b0;
      next_c = c;

      // Two-stage synchronisers run even in Halt.
      next_c.ss_s1   = SS_N_IN;
      next_c.ss_s2   = c.ss_s1;
      next_c.miso_s1 = MISO_IN;
      next_c.miso_s2 = c.miso_s1;
      next_c.done_s1 = l.done_tgl;
      next_c.done_s2 = c.done_s1;
      next_c.done_s3 = c.done_s2;
      next_c.mid_s1  = l.mid;
      next_c.mid_s2  = c.mid_s1;

      // Halt entry arms wake-up only for a selected slave.
      if (HALT_MODE && !c.halted) begin
         next_c.halted = 1'b1;
         next_c.armed  = c.pe && !c.master && !ss_int; // see R20
      end else if (!HALT_MODE) begin
         next_c.halted = 1'b0;
         next_c.armed  = 1'b0;
      end

      // Master engine, stopped while halted.
      if (running && c.busy) begin // see R18
         if (c.div == MASTER_DIV_LAST) begin
            next_c.div = 3'h0;
            tick = 1'b1;
         end else begin
            next_c.div = c.div + 3'h1;
         end
      end
      if (tick) begin
         cap_now   = (c.edge_cnt != EDGE_LAST)
                     && (c.edge_cnt[0] == c.capture_edge_select); // see R1
         shift_now = (c.edge_cnt[0] != c.capture_edge_select)
                     && !(c.capture_edge_select && c.edge_cnt == 5'h00);
         if (c.edge_cnt != EDGE_LAST) begin
            next_c.sck      = !c.sck;
            next_c.edge_cnt = c.edge_cnt + 5'h01;
         end
         if (cap_now) begin
            next_c.cap_bit = c.miso_s2;
         end
         if (shift_now) begin
            mbyte     = {c.sh[6:0], c.cap_bit};
            next_c.sh = mbyte;
         end
         if (c.edge_cnt == EDGE_LAST) begin
            next_c.busy = 1'b0;
            master_done = 1'b1;
            dbyte       = mbyte;
         end
      end
      if (!next_c.busy) begin
         next_c.sck = c.clock_idle_level;
      end

      done_evt = master_done
                 || (slave_done && (running || c.armed)); // see R19

      // Completion flag: access-then-data clearing sequence.
      if (running && (CSR_RD || CSR_WR) && c.tcf) begin
         next_c.seen_tcf = 1'b1;
      end
      if (clr_tcf) begin
         next_c.tcf      = 1'b0;
         next_c.seen_tcf = 1'b0;
      end

      // Overrun clears on status read; a new overrun wins.
      if (running && CSR_RD) begin
         next_c.overrun_flag = 1'b0; // see R13
      end

      // A byte arriving over a pending completion is dropped.
      if (done_evt) begin
         if (c.tcf && !clr_tcf) begin
            next_c.overrun_flag = 1'b1; // see R10, R11, R19
         end else begin
            next_c.rx = dbyte; // see R12
         end
         next_c.tcf      = 1'b1;
         next_c.seen_tcf = 1'b0;
      end

      // Collision flag: status read arms, data read clears.
      if (running && CSR_RD && c.write_collision_flag) begin
         next_c.seen_write_collision_flag = 1'b1;
      end
      if (running && DR_RD && c.seen_write_collision_flag) begin
         next_c.write_collision_flag      = 1'b0; // see R16
         next_c.seen_write_collision_flag = 1'b0;
      end

      // Data write: collide, inhibit, start master or load slave data.
      if (collide) begin
         next_c.write_collision_flag = 1'b1; // see R14
      end else if (running && DR_WR && !(c.tcf && !c.seen_tcf)) begin
         if (c.master && c.pe) begin
            next_c.sh       = DR_WDATA;
            next_c.busy     = 1'b1;
            next_c.edge_cnt = 5'h00;
            next_c.div      = 3'h0;
         end else begin
            next_c.tx = DR_WDATA;
         end
      end

      // Soft select controls.
      if (running && CSR_WR) begin
         next_c.ssm = CSR_WDATA[CSR_SSM_BIT];
         next_c.soft_select_level = CSR_WDATA[CSR_SSI_BIT];
      end

      // Fault flag: status read arms, control write clears.
      if (running && CSR_RD && c.mode_fault_flag) begin
         next_c.seen_mode_fault_flag = 1'b1;
      end
      if (running && CR_WR) begin
         next_c.irq_en = CR_WDATA[CR_IRQ_EN_BIT];
         next_c.clock_idle_level   = CR_WDATA[CR_CLOCK_IDLE_LEVEL_BIT];
         next_c.capture_edge_select   = CR_WDATA[CR_CAPTURE_EDGE_SELECT_BIT];
         next_c.baud   = {CR_WDATA[CR_BAUD2_BIT], CR_WDATA[CR_BAUD1_BIT],
                          CR_WDATA[CR_BAUD0_BIT]};
         next_c.pe     = CR_WDATA[CR_PE_BIT]
                         && (!c.mode_fault_flag || c.seen_mode_fault_flag); // see R8
         next_c.master = CR_WDATA[CR_MASTER_BIT]
                         && (!c.mode_fault_flag || c.seen_mode_fault_flag); // see R8
         if (c.mode_fault_flag && c.seen_mode_fault_flag) begin
            next_c.mode_fault_flag      = 1'b0; // see R7
            next_c.seen_mode_fault_flag = 1'b0;
         end
      end

      // Master mode fault overrides everything else.
      if (fault) begin
         next_c.mode_fault_flag      = 1'b1; // see R4
         next_c.seen_mode_fault_flag = 1'b0;
         next_c.pe        = 1'b0; // see R5
         next_c.master    = 1'b0; // see R6
         next_c.busy      = 1'b0;
         next_c.sck       = c.clock_idle_level;
      end
   end

   // Core registers.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         c        <= '0;
         c.ss_s1  <= 1'b1;
         c.ss_s2  <= 1'b1;
         c.rx     <= DR_RESET_VALUE;
      end else begin
         c <= next_c;
      end
   end

   // Slave shifter on the capture edge of the master's clock.
   always_comb begin
      next_l = l;
      if (link_en) begin
         next_l.sh  = {((l.cnt == 3'h0) ? c.tx[6:0] : l.sh[6:0]), MOSI_IN};
         next_l.cnt = l.cnt + 3'h1;
         next_l.mid = (l.cnt != BIT_LAST);
         if (l.cnt == BIT_LAST) begin
            next_l.rx       = {l.sh[6:0], MOSI_IN};
            next_l.done_tgl = !l.done_tgl;
         end
      end
   end

   // Link-side registers.
   always_ff @(posedge link_clk or negedge RESETN) begin
      if (!RESETN) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // Checks on the CPU-clock side.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   a_fault_drops_master: assert property ( // see R3
      c.master && !ss_int && !c.halted |=> c.mode_fault_flag && !c.master)
      else $error("Fault did not drop master mode.");
   a_fault_drops_enable: assert property ( // see R5
      fault |=> !c.pe && SCK_OE_N && MOSI_OE_N)
      else $error("Fault left the pins driven.");
   a_fault_irq_raised: assert property ( // see R4
      fault && next_c.irq_en && !CPU_IRQ_MASK |=> IRQ)
      else $error("Fault raised no interrupt.");
   a_mode_fault_flag_blocks_set: assert property ( // see R8
      c.mode_fault_flag && !c.seen_mode_fault_flag && CR_WR && !c.halted
      |=> !c.pe && !c.master)
      else $error("Enable set while fault pending.");
   a_mode_fault_flag_needs_seq: assert property ( // see R7
      c.mode_fault_flag && !c.seen_mode_fault_flag && !(CSR_RD && !c.halted) |=> c.mode_fault_flag)
      else $error("Fault flag cleared without sequence.");
   a_overrun_sets: assert property ( // see R10
      done_evt && c.tcf && !clr_tcf |=> c.overrun_flag && c.tcf)
      else $error("Overrun not flagged.");
   a_overrun_keeps: assert property ( // see R12
      done_evt && c.tcf && !clr_tcf |=> $stable(c.rx))
      else $error("Receive buffer overwritten on overrun.");
   a_overrun_clear: assert property ( // see R13
      CSR_RD && !c.halted && !done_evt |=> !c.overrun_flag)
      else $error("Status read left overrun set.");
   a_collide_keeps: assert property ( // see R14
      collide && c.busy && !fault && c.div != MASTER_DIV_LAST
      |=> c.write_collision_flag && $stable(c.sh) && c.busy)
      else $error("Collision disturbed the transfer.");
   a_write_collision_flag_no_irq: assert property ( // see R15
      !c.tcf && !c.mode_fault_flag && !c.overrun_flag |-> !IRQ)
      else $error("Interrupt raised by collision alone.");
   a_write_collision_flag_write_keeps: assert property ( // see R16
      c.write_collision_flag && DR_WR && !DR_RD |=> c.write_collision_flag)
      else $error("Data write cleared collision flag.");
   a_halt_frozen: assert property ( // see R18
      c.halted && HALT_MODE && !done_evt
      |=> $stable(c.rx) && $stable(c.tx) && $stable(c.sh))
      else $error("Registers changed in Halt.");
   a_halt_no_fault_wake: assert property ( // see R21
      c.halted && !c.tcf |-> !WAKE_HALT)
      else $error("Halt wake without completion.");
   a_master_byte_time: assert property ( // see R1
      $rose(c.busy) |-> c.busy [*8] ##1 c.busy)
      else $error("Master byte ended too soon.");

   // Wake-up, masking and collision flag checks.
   a_halt_needs_arm: assert property ( // see R20
      !c.armed |-> !WAKE_HALT)
      else $error("Halt wake without arming at entry.");
   a_mask_blocks_irq: assert property ( // see R22
      CPU_IRQ_MASK || !c.irq_en |-> !IRQ)
      else $error("Interrupt raised while masked.");
   a_collide_flags: assert property ( // see R14
      collide |=> c.write_collision_flag)
      else $error("Collision not flagged.");

   c_master_byte: cover property (master_done);
   c_slave_byte: cover property (slave_done && !c.halted);
   c_mode_fault: cover property (fault);
   c_overrun: cover property (done_evt && c.tcf);
   c_halt_wake: cover property (WAKE_HALT);

endmodule

// ==== sefp_peer.sv ====
`timescale 1ns/1ps
// Far-side peer: a master that drives the design's slave link, and a
// slave that answers the design when the design is master.
module sefp_peer (
   // Link towards the design acting as slave.
   output logic       sck,
   output logic       ss_n,
   output logic       mosi,
   input  wire logic  miso,
   // Link from the design acting as master.
   input  wire logic  m_sck,
   input  wire logic  m_mosi,
   output logic       m_miso,
   // Timing mode shared with the design.
   input  wire logic  clock_idle_level,
   input  wire logic  capture_edge_select
);
   logic [7:0] tx;
   logic [7:0] rx;
   int         k;

   // Lines start idle, with the select released high.
   initial begin
      sck = 1'h0;
      ss_n = 1'h1;
      mosi = 1'h0;
      m_miso = 1'h1;
      k = 8;
   end

   // One byte as master, MSB first; the clock stands still outside it.
   task automatic xfer(input logic [7:0] d, output logic [7:0] got);
      sck = clock_idle_level;
      ss_n = 1'h0;
      // The design synchronises the select over CLK edges first.
      #192;
      for (int i = 7; i >= 0; i--) begin
         if (!capture_edge_select) mosi = d[i];
         #24 sck = ~sck;
         if (capture_edge_select) mosi = d[i];
         else got[i] = miso;
         #24 sck = ~sck;
         if (capture_edge_select) got[i] = miso;
      end
      #48 ss_n = 1'h1;
      mosi = ~mosi; // Released data shows the inverse of its last bit.
   endtask

   // Loads the byte that the slave role returns on the next transfer.
   task automatic arm(input logic [7:0] d);
      tx = d;
      rx = 8'h00;
      k = 0;
      m_miso = d[7];
   endtask

   // Slave role: sample on the capture edge, launch on the other edge.
   always @(m_sck) begin
      if (m_sck ^ clock_idle_level ^ capture_edge_select) begin
         rx = {rx[6:0], m_mosi};
         k = k + 1;
      end else if (k < 8) begin
         m_miso = tx[7 - k];
      end else begin
         m_miso = ~m_miso;
      end
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import sefp_pkg::*;
   localparam int CR  = 0;
   localparam int SRD = 1;
   localparam int SWR = 2;
   localparam int DRD = 3;
   localparam int DWR = 4;
   logic       clk, rst_n, mask, halt, ss_tb, clock_idle_level, capture_edge_select;
   logic [4:0] stb;
   logic [7:0] wd, cr_q, csr_q, dr_q, got;
   logic       irq, wake, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
   logic       miso_o, miso_oe_n, p_sck, p_ss_n, p_mosi, p_miso;
   int         n_fail;
   int         tests_run;

   // Block under test; the select pin is the AND of peer and bench.
   sefp_spi DUT (
      .CLK(clk), .RESETN(rst_n),
      .CR_WR(stb[CR]), .CR_WDATA(wd), .CR_RDATA(cr_q),
      .CSR_RD(stb[SRD]), .CSR_WR(stb[SWR]), .CSR_WDATA(wd),
      .CSR_RDATA(csr_q), .DR_RD(stb[DRD]), .DR_WR(stb[DWR]),
      .DR_WDATA(wd), .DR_RDATA(dr_q), .CPU_IRQ_MASK(mask),
      .HALT_MODE(halt), .IRQ(irq), .WAKE_HALT(wake),
      .SS_N_IN(p_ss_n & ss_tb), .SCK_IN(p_sck), .SCK_OUT(sck_o),
      .SCK_OE_N(sck_oe_n), .MOSI_IN(p_mosi), .MOSI_OUT(mosi_o),
      .MOSI_OE_N(mosi_oe_n), .MISO_IN(p_miso), .MISO_OUT(miso_o),
      .MISO_OE_N(miso_oe_n)
   );

   // Released data lines show the inverse, so stale values never match.
   sefp_peer peer (
      .sck(p_sck), .ss_n(p_ss_n), .mosi(p_mosi),
      .miso(miso_oe_n ? ~miso_o : miso_o),
      .m_sck(sck_o), .m_mosi(mosi_oe_n ? ~mosi_o : mosi_o),
      .m_miso(p_miso), .clock_idle_level(clock_idle_level), .capture_edge_select(capture_edge_select)
   );

   // Core clock, 50 ns period.
   always #25 clk = ~clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One strobe pulse; readbacks are looked at just after it lands.
   task automatic acc(input int k, input logic [7:0] d);
      @(posedge clk);
      stb[k] <= 1'h1;
      wd <= d;
      @(posedge clk);
      stb <= 5'h00;
      #1;
   endtask

   // Waits a bounded time for a status bit to rise.
   task automatic wait_bit(input int b);
      for (int n = 0; n < 400 && csr_q[b] !== 1'h1; n++) @(negedge clk);
      #1;
   endtask

   task automatic t_reset;
      chk(cr_q, CR_RESET_VALUE);
      chk(csr_q, CSR_RESET_VALUE);
      chk(dr_q, DR_RESET_VALUE);
      chk({5'h00, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
      chk({6'h00, irq, wake}, 8'h00);
   endtask

   // Every clock mode, first as master, then as slave.
   task automatic t_modes;
      logic [7:0] d;
      for (int m = 0; m < 4; m++) begin
         d = 8'hA5 ^ 8'(m * 17);
         acc(CR, 8'h00);
         clock_idle_level = m[1];
         capture_edge_select = m[0];
         acc(CR, {4'h5, clock_idle_level, capture_edge_select, 2'h0});
         repeat (2) @(posedge clk);
         peer.arm(~d);
         acc(DWR, d);
         wait_bit(CSR_TCF_BIT);
         chk(peer.rx, d);
         chk(dr_q, ~d);
         chk({7'h00, sck_o}, {7'h00, clock_idle_level});
         acc(SRD, 8'h00);
         acc(DRD, 8'h00);
         acc(CR, 8'h00);
         acc(CR, {4'h4, clock_idle_level, capture_edge_select, 2'h0});
         acc(DWR, d);
         peer.xfer(~d, got);
         wait_bit(CSR_TCF_BIT);
         chk(got, d);
         chk(dr_q, ~d);
         acc(SRD, 8'h00);
         acc(DRD, 8'h00);
      end
   endtask

   // Two bytes arrive before the flag is cleared.
   task automatic t_ovr;
      acc(CR, 8'h00);
      clock_idle_level = 1'h0;
      capture_edge_select = 1'h0;
      acc(CR, 8'hC0);
      peer.xfer(8'hA5, got);
      wait_bit(CSR_TCF_BIT);
      peer.xfer(8'h3C, got);
      wait_bit(CSR_OVR_BIT);
      chk(csr_q & 8'hF0, 8'hA0);
      chk({7'h00, irq}, 8'h01);
      chk(dr_q, 8'hA5);
      acc(SRD, 8'h00);
      chk(csr_q & 8'hF0, 8'h80);
      acc(DRD, 8'h00);
      chk({7'h00, irq}, 8'h00);
   endtask

   // A second data write while the master shifts collides.
   task automatic t_write_collision_flag;
      acc(CR, 8'hD0);
      repeat (2) @(posedge clk);
      peer.arm(8'h00);
      acc(DWR, 8'h96);
      acc(DWR, 8'h11);
      chk(csr_q & 8'hC0, 8'h40);
      chk({7'h00, irq}, 8'h00);
      wait_bit(CSR_TCF_BIT);
      chk(peer.rx, 8'h96);
      acc(SRD, 8'h00);
      peer.arm(8'h00);
      acc(DWR, 8'h22);
      chk(csr_q & 8'h40, 8'h40);
      wait_bit(CSR_TCF_BIT);
      acc(SRD, 8'h00);
      acc(DRD, 8'h00);
      chk(csr_q & 8'hC0, 8'h00);
   endtask

   // Select pulled low under an enabled master.
   task automatic t_mode_fault_flag;
      @(posedge clk) ss_tb <= 1'h0;
      wait_bit(CSR_MODE_FAULT_FLAG_BIT);
      chk(csr_q & 8'h10, 8'h10);
      chk({7'h00, irq}, 8'h01);
      chk(cr_q, 8'h80);
      chk({6'h00, sck_oe_n, mosi_oe_n}, 8'h03);
      @(posedge clk) mask <= 1'h1;
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00);
      @(posedge clk) ss_tb <= 1'h1;
      repeat (3) @(posedge clk);
      acc(CR, 8'hD0);
      chk(cr_q, 8'h80);
      acc(SRD, 8'h00);
      acc(CR, 8'hD0);
      chk(csr_q & 8'h10, 8'h00);
      chk(cr_q, 8'hD0);
      @(posedge clk) mask <= 1'h0;
      acc(CR, 8'h00);
   endtask

   // Soft select held low under master mode also gives a fault.
   task automatic t_soft;
      acc(SWR, 8'h02);
      acc(CR, 8'h50);
      wait_bit(CSR_MODE_FAULT_FLAG_BIT);
      chk(csr_q & 8'h13, 8'h12);
      chk(cr_q, 8'h00);
      acc(SWR, 8'h03);
      acc(SRD, 8'h00);
      acc(CR, 8'h00);
      chk(csr_q & 8'h13, 8'h03);
      acc(SWR, 8'h00);
   endtask

   // Armed slave in Halt is woken by a completed byte.
   task automatic t_halt;
      acc(CR, 8'hC0);
      @(posedge clk) ss_tb <= 1'h0;
      repeat (4) @(posedge clk);
      halt <= 1'h1;
      acc(CR, 8'h00);
      chk(cr_q, 8'hC0);
      peer.xfer(8'h69, got);
      for (int n = 0; n < 100 && wake !== 1'h1; n++) @(negedge clk);
      #1;
      chk({7'h00, wake}, 8'h01);
      @(posedge clk) halt <= 1'h0;
      ss_tb <= 1'h1;
      #1;
      chk(dr_q, 8'h69);
   endtask

   task automatic conclude;
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Reset for eight cycles, let the select sync settle, then run.
   initial begin
      clk = 1'h0;
      rst_n = 1'h0;
      stb = 5'h00;
      wd = 8'h00;
      mask = 1'h0;
      halt = 1'h0;
      ss_tb = 1'h1;
      clock_idle_level = 1'h0;
      capture_edge_select = 1'h0;
      n_fail = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      #1;
      t_reset();
      t_modes();
      t_ovr();
      t_write_collision_flag();
      t_mode_fault_flag();
      t_soft();
      t_halt();
      conclude();
   end

   // Watchdog: the tests need far less than 40000 cycles.
   initial begin
      #2000000;
      n_fail++;
      conclude();
   end
endmodule
